/* File: spp_consts.svh */
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SPP_OFS_DIR 6'h00
`define SPP_OFS_LVL 6'h04
`define SPP_OFS_LAT 6'h08
`define SPP_OFS_ODC 6'h0C
`define SPP_OFS_ANS 6'h10
`define SPP_OFS_PUE 6'h14
`define SPP_OFS_PDE 6'h18
`define SPP_OFS_CNE 6'h1C
`define SPP_OFS_IRQ1 6'h20

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define SPP_IRQ1_LSB 8
`define SPP_IRQ1_MSB 14
`define SPP_SEL_VSS 7'h00
`define SPP_SEL_COMPARATOR_ONE_OUTPUT 7'h01
`define SPP_SEL_REMAPPABLE_INPUT_121 7'h79
`define SPP_DIR_RST 1'b1
`define SPP_CFG_RST 1'b0

`endif

/* File: spp_pkg.sv */
package spp_pkg;
    // Pad-side drive of one pin
    typedef struct packed {
        logic dout;
        logic oe;
    } spp_pad_s;

    // Peripheral request on one pin
    typedef struct packed {
        logic en;
        logic active;
        logic dout;
        logic oe;
    } spp_periph_s;

    typedef enum logic {
        SPP_IDLE,
        SPP_DONE
    } spp_bus_e;
endpackage : spp_pkg

/* File: spp_pin_mux.sv */
`timescale 1ns/10ps
`default_nettype none
`include "spp_consts.svh"
module spp_pin_mux
    import spp_pkg::*;
(
    input wire spp_periph_s periph,
    input wire logic input_only,
    input wire logic implemented,
    input wire logic dir_in,
    input wire logic latch,
    input wire logic open_drain,
    input wire logic pin_sync,
    output var spp_pad_s pad,
    output logic periph_in
);
    logic periph_owns;
    logic port_drives;

    // ----------------------------------------
    // Ownership of the output pair
    // ----------------------------------------
    // Input-only functions never claim the driver
    always_comb begin
        periph_owns = periph.en & periph.active & ~input_only & implemented;
        // Open drain drives only the low level
        port_drives = implemented & ~dir_in & ~(open_drain & latch);
        pad.dout = periph_owns ? periph.dout : (open_drain ? 1'b0 : latch);
        pad.oe = periph_owns ? periph.oe : port_drives;
        // Block loop-through: while the port drives the pin, the peripheral input reads low
        periph_in = (!periph_owns && port_drives) ? 1'b0 : pin_sync;
    end
endmodule : spp_pin_mux
`default_nettype wire

/* File: spp_irq1_sel.sv */
`timescale 1ns/10ps
`default_nettype none
`include "spp_consts.svh"
module spp_irq1_sel
    import spp_pkg::*;
#(
    parameter int NSRC = 128
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [6:0] irq1_source_select,
    input wire logic comparator_one_output,
    input wire logic [NSRC-1:0] remappable_pin,
    output logic external_interrupt_one
);
    logic sel_r;
    logic sel_nxt;

    // The select field is 7 bits, so more than 128 sources cannot be reached
    if (NSRC < 2 || NSRC > 128) begin : g_bad_nsrc
        $error("spp_irq1_sel: NSRC out of range");
    end

    // ----------------------------------------
    // Source pick; codes past the vector read as low
    // ----------------------------------------
    always_comb begin
        if (irq1_source_select == `SPP_SEL_VSS) begin
            sel_nxt = 1'b0;
        end else if (irq1_source_select == `SPP_SEL_COMPARATOR_ONE_OUTPUT) begin
            sel_nxt = comparator_one_output;
        end else if (32'(irq1_source_select) < NSRC) begin
            sel_nxt = remappable_pin[irq1_source_select];
        end else begin
            sel_nxt = 1'b0;
        end
    end

    // Registered to keep the wide mux off the interrupt path
    always_ff @(posedge clock) begin
        if (srst) begin
            sel_r <= 1'b0;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    assign external_interrupt_one = sel_r;
endmodule : spp_irq1_sel
`default_nettype wire

/* File: spp_port.sv */
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "spp_consts.svh"
module spp_port
    import spp_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] IMPL_MASK = '1,
    parameter logic [WIDTH-1:0] INPUT_ONLY = '0,
    parameter int NSRC = 128
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire spp_periph_s [WIDTH-1:0] periph,
    output logic [WIDTH-1:0] periph_in,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pull_up_en,
    output logic [WIDTH-1:0] pull_down_en,
    input wire logic comparator_one_output,
    input wire logic [NSRC-1:0] remappable_pin,
    output logic external_interrupt_one
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Registers are 16 bits wide, so a wider port cannot be served
    if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
        $error("spp_port: WIDTH must be 1..16");
    end

    // Byte-enable merge of a 16-bit register, used by every writable register except the interrupt one select
    function automatic logic [WIDTH-1:0] merge(input logic [WIDTH-1:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [15:0] o;
        o = 16'(old);
        if (be[0]) o[7:0] = wd[7:0];
        if (be[1]) o[15:8] = wd[15:8];
        return o[WIDTH-1:0] & IMPL_MASK;
    endfunction : merge

    // ----------------------------------------
    // Avalon slave handshake
    // ----------------------------------------
    // One wait cycle per access; the answer comes on the second edge
    spp_bus_e bus_r, bus_nxt;
    logic req;
    logic take;
    assign req = read | write;
    assign waitrequest = req & (bus_r == SPP_IDLE);
    assign take = req & ~waitrequest;

    always_comb begin
        case (bus_r)
            SPP_IDLE: bus_nxt = req ? SPP_DONE : SPP_IDLE;
            SPP_DONE: bus_nxt = SPP_IDLE;
            default: bus_nxt = SPP_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            bus_r <= SPP_IDLE;
        end else begin
            bus_r <= bus_nxt;
        end
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [WIDTH-1:0] dir_r, dir_nxt, lat_r, lat_nxt, odc_r, odc_nxt, ans_r, ans_nxt;
    logic [WIDTH-1:0] pue_r, pue_nxt, pde_r, pde_nxt, cne_r, cne_nxt;
    logic [6:0] sel_r, sel_nxt;
    logic wr;
    assign wr = write & take;

    // Write decode; the level register's write lands in the latch
    always_comb begin
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        odc_nxt = odc_r;
        ans_nxt = ans_r;
        pue_nxt = pue_r;
        pde_nxt = pde_r;
        cne_nxt = cne_r;
        sel_nxt = sel_r;
        if (wr) begin
            if (address == `SPP_OFS_DIR) begin
                dir_nxt = merge(dir_r, writedata, byteenable);
            end else if (address == `SPP_OFS_LVL) begin
                lat_nxt = merge(lat_r, writedata, byteenable);
            end else if (address == `SPP_OFS_LAT) begin
                lat_nxt = merge(lat_r, writedata, byteenable);
            end else if (address == `SPP_OFS_ODC) begin
                odc_nxt = merge(odc_r, writedata, byteenable);
            end else if (address == `SPP_OFS_ANS) begin
                ans_nxt = merge(ans_r, writedata, byteenable);
            end else if (address == `SPP_OFS_PUE) begin
                pue_nxt = merge(pue_r, writedata, byteenable);
            end else if (address == `SPP_OFS_PDE) begin
                pde_nxt = merge(pde_r, writedata, byteenable);
            end else if (address == `SPP_OFS_CNE) begin
                cne_nxt = merge(cne_r, writedata, byteenable);
            end else if (address == `SPP_OFS_IRQ1) begin
                if (byteenable[1]) sel_nxt = writedata[`SPP_IRQ1_MSB:`SPP_IRQ1_LSB];
            end
        end
    end

    // Direction resets to input on every pin that exists
    always_ff @(posedge clock) begin
        if (srst) begin
            dir_r <= {WIDTH{`SPP_DIR_RST}} & IMPL_MASK;
            lat_r <= {WIDTH{`SPP_CFG_RST}};
            odc_r <= {WIDTH{`SPP_CFG_RST}};
            ans_r <= {WIDTH{`SPP_CFG_RST}};
            pue_r <= {WIDTH{`SPP_CFG_RST}};
            pde_r <= {WIDTH{`SPP_CFG_RST}};
            cne_r <= {WIDTH{`SPP_CFG_RST}};
            sel_r <= `SPP_SEL_VSS;
        end else begin
            dir_r <= dir_nxt;
            lat_r <= lat_nxt;
            odc_r <= odc_nxt;
            ans_r <= ans_nxt;
            pue_r <= pue_nxt;
            pde_r <= pde_nxt;
            cne_r <= cne_nxt;
            sel_r <= sel_nxt;
        end
    end

    // ----------------------------------------
    // Pin input synchroniser
    // ----------------------------------------
    // Pads are asynchronous to the core; two flops before any reader
    logic [WIDTH-1:0] meta_r, sync_r, lvl_view;
    always_ff @(posedge clock) begin
        if (srst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
        end
    end
    // Analog pins read low digitally; missing pins always low
    assign lvl_view = sync_r & ~ans_r & IMPL_MASK;

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    logic [31:0] rd_r, rd_nxt;
    always_comb begin
        rd_nxt = rd_r;
        if (read && waitrequest) begin
            if (address == `SPP_OFS_DIR) begin
                rd_nxt = 32'(dir_r);
            end else if (address == `SPP_OFS_LVL) begin
                rd_nxt = 32'(lvl_view);
            end else if (address == `SPP_OFS_LAT) begin
                rd_nxt = 32'(lat_r);
            end else if (address == `SPP_OFS_ODC) begin
                rd_nxt = 32'(odc_r);
            end else if (address == `SPP_OFS_ANS) begin
                rd_nxt = 32'(ans_r);
            end else if (address == `SPP_OFS_PUE) begin
                rd_nxt = 32'(pue_r);
            end else if (address == `SPP_OFS_PDE) begin
                rd_nxt = 32'(pde_r);
            end else if (address == `SPP_OFS_CNE) begin
                rd_nxt = 32'(cne_r);
            end else if (address == `SPP_OFS_IRQ1) begin
                rd_nxt = {17'h00000, sel_r, 8'h00};
            end else begin
                rd_nxt = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rd_r <= 32'h00000000;
        end else begin
            rd_r <= rd_nxt;
        end
    end
    assign readdata = rd_r;

    // ----------------------------------------
    // Per-pin output muxes
    // ----------------------------------------
    spp_pad_s [WIDTH-1:0] pad;
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        spp_pin_mux u_mux (
            .periph(periph[i]),
            .input_only(INPUT_ONLY[i]),
            .implemented(IMPL_MASK[i]),
            .dir_in(dir_r[i]),
            .latch(lat_r[i]),
            .open_drain(odc_r[i]),
            .pin_sync(lvl_view[i]),
            .pad(pad[i]),
            .periph_in(periph_in[i])
        );
        assign pin_o[i] = pad[i].dout;
        assign pin_oe[i] = pad[i].oe;
    end
    assign pull_up_en = pue_r;
    assign pull_down_en = pde_r;

    // ----------------------------------------
    // Interrupt one source select
    // ----------------------------------------
    spp_irq1_sel #(.NSRC(NSRC)) u_irq1 (
        .clock(clock),
        .srst(srst),
        .irq1_source_select(sel_r),
        .comparator_one_output(comparator_one_output),
        .remappable_pin(remappable_pin),
        .external_interrupt_one(external_interrupt_one)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    periph_owns_a: assert property ((periph[0].en && periph[0].active && !INPUT_ONLY[0] && IMPL_MASK[0])
        |-> pin_oe[0] == periph[0].oe && pin_o[0] == periph[0].dout)
        else $error("peripheral does not own pin 0");
    port_owns_a: assert property (!(periph[0].en && periph[0].active) && IMPL_MASK[0] && !odc_r[0]
        |-> pin_oe[0] == !dir_r[0] && pin_o[0] == lat_r[0])
        else $error("port does not own pin 0");
    no_loop_a: assert property (pin_oe[0] && !(periph[0].en && periph[0].active) |-> !periph_in[0])
        else $error("port output loops into peripheral");
    dir_input_a: assert property (dir_r[0] && !(periph[0].en && periph[0].active) |-> !pin_oe[0])
        else $error("input pin driven");
    reset_dir_a: assert property ($fell(srst) |-> dir_r == IMPL_MASK)
        else $error("direction not input after reset");
    lat_read_a: assert property (read && waitrequest && address == `SPP_OFS_LAT
        |=> readdata == 32'($past(lat_r)))
        else $error("latch read wrong");
    lvl_write_a: assert property (write && !waitrequest && address == `SPP_OFS_LVL && byteenable[1:0] == 2'h3
        |=> lat_r == (16'($past(writedata)) & IMPL_MASK))
        else $error("level write did not load latch");
    lvl_read_a: assert property (read && waitrequest && address == `SPP_OFS_LVL && ans_r == '0
        |=> readdata == 32'($past(sync_r) & IMPL_MASK))
        else $error("level read wrong");
    unimpl_zero_a: assert property ((dir_r & ~IMPL_MASK) == '0 && (lat_r & ~IMPL_MASK) == '0)
        else $error("unimplemented bit set");
    sel_read_a: assert property (read && waitrequest && address == `SPP_OFS_IRQ1
        |=> readdata[31:15] == '0 && readdata[7:0] == '0)
        else $error("select reserved bits nonzero");
    irq1_cmp_a: assert property (sel_r == `SPP_SEL_COMPARATOR_ONE_OUTPUT && $stable(sel_r)
        |=> external_interrupt_one == $past(comparator_one_output))
        else $error("comparator routing wrong");
    wait_one_a: assert property (req && waitrequest && $stable(address) |=> !waitrequest)
        else $error("bus answer late");
    // The select resets to the grounded code, so the interrupt input starts low
    reset_sel_a: assert property ($fell(srst) |-> sel_r == `SPP_SEL_VSS && !external_interrupt_one)
        else $error("select not cleared by reset");
    irq1_off_a: assert property (sel_r == `SPP_SEL_VSS && $stable(sel_r) |=> !external_interrupt_one)
        else $error("grounded select not low");
    unimpl_pad_a: assert property ((pin_oe & ~IMPL_MASK) == '0 && (lvl_view & ~IMPL_MASK) == '0)
        else $error("missing pin active");
    periph_view_a: assert property (!pin_oe[0] |-> periph_in[0] == lvl_view[0])
        else $error("peripheral input lost");
    periph_read_a: assert property (periph[0].en && periph[0].active && !INPUT_ONLY[0] && IMPL_MASK[0]
        |-> periph_in[0] == lvl_view[0])
        else $error("owned pin not readable");

    rd_cov_c: cover property (read && !waitrequest && address == `SPP_OFS_LVL);
    own_cov_c: cover property (periph[0].en && periph[0].active);
    out_cov_c: cover property (pin_oe[0] && !dir_r[0]);
    sel_cov_c: cover property (sel_r == `SPP_SEL_REMAPPABLE_INPUT_121);
    lat_wr_cov_c: cover property (write && !waitrequest && address == `SPP_OFS_LAT);
endmodule : spp_port
`default_nettype wire

/* File: spp_pad_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Pad model: resolves each pin from all drivers
// ----------------------------------------
module spp_pad_model (
    input wire logic clock,
    input wire logic [15:0] pin_o,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pull_up_en,
    input wire logic [15:0] pull_down_en,
    input wire logic [15:0] ext_lvl,
    input wire logic [15:0] ext_en,
    output logic [15:0] pin_i
);
    logic [15:0] float_r = 16'h5555;

    // A floating pad toggles every cycle so a stale value never looks right
    always @(posedge clock) begin
        float_r <= ~float_r;
    end

    // Port or peripheral drive wins, then the outside source, then pulls
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_lvl) |
                   (~pin_oe & ~ext_en & (pull_up_en | (~pull_down_en & float_r)));
endmodule : spp_pad_model
`default_nettype wire

/* File: tb_shared_pin_parallel_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "spp_consts.svh"
module tb_shared_pin_parallel_port
    import spp_pkg::*;
;
    localparam logic [15:0] IMPL = 16'h7FFF; // Top bit missing on this variant
    localparam logic [15:0] IN_ONLY = 16'h0002; // Pin 1 shares only inputs
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    spp_periph_s [15:0] periph = '0;
    logic [15:0] periph_in, pin_i, pin_o, pin_oe, pull_up_en, pull_down_en;
    logic comparator_one_output = 1'b0;
    logic [127:0] remappable_pin = '0;
    logic external_interrupt_one;
    logic [15:0] ext_lvl = 16'h0000;
    logic [15:0] ext_en = 16'hFFFF;
    logic [31:0] q;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    always #5 clock = ~clock;

    spp_port #(.WIDTH(16), .IMPL_MASK(IMPL), .INPUT_ONLY(IN_ONLY), .NSRC(128)) DUT (
        .clock(clock), .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'h3), .readdata(readdata), .waitrequest(waitrequest),
        .periph(periph), .periph_in(periph_in), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .comparator_one_output(comparator_one_output), .remappable_pin(remappable_pin),
        .external_interrupt_one(external_interrupt_one)
    );

    spp_pad_model PADS (
        .clock(clock), .pin_o(pin_o), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_i(pin_i)
    );

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task end_of_test;
        $display("Counts: checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Avalon access; waitrequest and read data are taken at the rising edge
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // Idle edge so the next request never lands in the same time step
        @(posedge clock);
    endtask : bus

    task settle(input int n);
        repeat (n) @(posedge clock);
    endtask : settle

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        bus(1'b0, `SPP_OFS_DIR, 32'h0);
        chk("dir after reset", IMPL, q[15:0]);
        bus(1'b0, `SPP_OFS_IRQ1, 32'h0);
        chk("irq1 select reset", 16'h0000, q[15:0]);
        chk("pin_oe after reset", 16'h0000, pin_oe);
        $display("test reset done");
    endtask : t_reset

    task t_latch;
        ext_lvl <= 16'h8F0F;
        bus(1'b1, `SPP_OFS_LAT, 32'hFFFF);
        bus(1'b0, `SPP_OFS_LAT, 32'h0);
        chk("latch missing bit", IMPL, q[15:0]);
        bus(1'b1, `SPP_OFS_LAT, 32'h5A3C);
        bus(1'b0, `SPP_OFS_LAT, 32'h0);
        chk("latch readback", 16'h5A3C, q[15:0]);
        bus(1'b0, `SPP_OFS_LVL, 32'h0);
        chk("level reads pins", 16'h0F0F, q[15:0]);
        bus(1'b1, `SPP_OFS_LVL, 32'h1234);
        bus(1'b0, `SPP_OFS_LAT, 32'h0);
        chk("level write loads latch", 16'h1234, q[15:0]);
        $display("test latch done");
    endtask : t_latch

    task t_dir;
        bus(1'b1, `SPP_OFS_LAT, 32'h00C3);
        bus(1'b1, `SPP_OFS_DIR, 32'hFF00);
        chk("low byte drives", 16'h00FF, pin_oe);
        chk("port output data", 16'h00C3, pin_o & 16'h00FF);
        chk("no loop through", 16'h0000, periph_in & 16'h00FF);
        settle(3);
        bus(1'b0, `SPP_OFS_LVL, 32'h0);
        chk("mixed level read", 16'h0FC3, q[15:0]);
        $display("test direction done");
    endtask : t_dir

    task t_periph;
        periph[2] <= '{en: 1'b1, active: 1'b1, dout: 1'b1, oe: 1'b1};
        periph[6] <= '{en: 1'b1, active: 1'b0, dout: 1'b0, oe: 1'b0};
        periph[0] <= '{en: 1'b1, active: 1'b1, dout: 1'b0, oe: 1'b1};
        periph[1] <= '{en: 1'b1, active: 1'b1, dout: 1'b0, oe: 1'b1};
        settle(1);
        chk("periph owns pin", 16'h0004, pin_o & pin_oe & 16'h0005);
        chk("idle periph leaves port", 16'h0040, pin_o & pin_oe & 16'h0040);
        chk("input-only pin stays port", 16'h0002, pin_o & pin_oe & 16'h0002);
        settle(3);
        chk("periph sees its pin", 16'h0004, periph_in & 16'h0007);
        bus(1'b0, `SPP_OFS_LVL, 32'h0);
        chk("owned pin readable", 16'h0FC6, q[15:0]);
        periph <= '0;
        $display("test peripheral done");
    endtask : t_periph

    task irq_case(input logic [6:0] code, input logic cmp, input logic [127:0] rp, input logic exp);
        bus(1'b1, `SPP_OFS_IRQ1, {17'h0, code, 8'h00});
        comparator_one_output <= cmp;
        remappable_pin <= rp;
        settle(2);
        chk("irq1 source", {15'h0, exp}, {15'h0, external_interrupt_one});
    endtask : irq_case

    task t_irq;
        bus(1'b1, `SPP_OFS_IRQ1, 32'hFFFF);
        bus(1'b0, `SPP_OFS_IRQ1, 32'h0);
        chk("irq1 select bits", 16'h7F00, q[15:0]);
        irq_case(`SPP_SEL_VSS, 1'b1, '1, 1'b0);
        irq_case(`SPP_SEL_COMPARATOR_ONE_OUTPUT, 1'b1, '0, 1'b1);
        irq_case(`SPP_SEL_COMPARATOR_ONE_OUTPUT, 1'b0, '1, 1'b0);
        irq_case(`SPP_SEL_REMAPPABLE_INPUT_121, 1'b1, ~(128'h1 << 121), 1'b0);
        irq_case(`SPP_SEL_REMAPPABLE_INPUT_121, 1'b0, 128'h1 << 121, 1'b1);
        $display("test irq1 select done");
    endtask : t_irq

    // Storage registers and one unmapped place; written next to last, before the second reset, as they alter pads
    task t_regs;
        logic [5:0] ofs [5];
        ofs = '{`SPP_OFS_ODC, `SPP_OFS_ANS, `SPP_OFS_PUE, `SPP_OFS_PDE, `SPP_OFS_CNE};
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, ofs[i], 32'h0A50 + i);
            bus(1'b0, ofs[i], 32'h0);
            chk("config readback", 16'h0A50 + 16'(i), q[15:0]);
        end
        chk("pull-up output", 16'h0A52, pull_up_en);
        chk("pull-down output", 16'h0A53, pull_down_en);
        // Analog-selected pins must read low whatever the pad shows
        bus(1'b0, `SPP_OFS_LVL, 32'h0);
        chk("analog pins read low", 16'h0000, q[15:0] & 16'h0A51);
        bus(1'b1, 6'h3C, 32'hFFFF);
        bus(1'b0, 6'h3C, 32'h0);
        chk("unmapped reads zero", 16'h0000, q[15:0]);
        $display("test registers done");
    endtask : t_regs

    // Reset in mid-run must bring back inputs and the grounded select
    task t_rerst;
        bus(1'b1, `SPP_OFS_DIR, 32'h0000);
        bus(1'b1, `SPP_OFS_IRQ1, 32'h0500);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        bus(1'b0, `SPP_OFS_DIR, 32'h0);
        chk("dir after second reset", IMPL, q[15:0]);
        bus(1'b0, `SPP_OFS_IRQ1, 32'h0);
        chk("select after second reset", 16'h0000, q[15:0]);
        $display("test second reset done");
    endtask : t_rerst

    // ----------------------------------------
    // Timeout and main sequence
    // ----------------------------------------
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_latch();
        t_dir();
        t_periph();
        t_irq();
        t_regs();
        t_rerst();
        end_of_test();
    end
endmodule : tb_shared_pin_parallel_port
`default_nettype wire
